// [common/cal_trig_pkg.sv]
// constants for the calibration and trigger register bank
// assumes a 16-bit register port with byte offsets from the card base
//
// Function
// - calibration bus connect bit 15 follows writes; reads return last value
// - busy bit 14 reads one during conversion, zero when result ready
// - writing one to bit 14 starts a conversion; host never writes zero mid-run
// - bit 13 selects voltage when one, current when zero; readable
// - bit 12 enables channel selector, else selector high impedance; readable
// - bits 11..8 hold channel code 0..15 for channels 1..16; readable
// - channel code reaches selector only while selector enable is one
// - low byte of calibration read gives latest conversion result
// - write bit 7 selects normal scaling or scaling divided by 13.7
// - channel count field reads all ones for 8, zeros for 16 channels
// - bits 2..0 mirror the three terminal ident lines
// - any write at 0c raises one trigger when software source selected
// - trigger control bit 15 turns the trigger system on or off
// - bits 8..6 pick backplane line driven in relay-out mode
// - bits 5..4 code 00 receive-only, 11 relay-out
// - bits 3..0 pick lines 0..7, software 1000, external 1001
// - relay-out accepts selected input and drives the drive line; lines differ
package cal_trig_pkg;
  localparam logic [4:0] off_cal_ctrl = 5'h08;
  localparam logic [4:0] off_card_cfg = 5'h0a;
  localparam logic [4:0] off_sw_trig = 5'h0c;
  localparam logic [4:0] off_trig_ctrl = 5'h0e;
  localparam int bit_bus_en = 15;
  localparam int bit_adc_busy = 14;
  localparam int bit_mode_volt = 13;
  localparam int bit_mux_en = 12;
  localparam int chan_hi = 11;
  localparam int chan_lo = 8;
  localparam int bit_adc_scale = 7;
  localparam int res_hi = 7;
  localparam int res_lo = 0;
  localparam int bit_trig_en = 15;
  localparam int drv_hi = 8;
  localparam int drv_lo = 6;
  localparam int mode_hi = 5;
  localparam int mode_lo = 4;
  localparam int src_hi = 3;
  localparam int src_lo = 0;
  localparam int cfg_hi = 5;
  localparam int cfg_lo = 3;
  localparam int term_hi = 2;
  localparam int term_lo = 0;
  localparam logic [1:0] mode_receive = 2'h0;
  localparam logic [1:0] mode_relay = 2'h3;
  localparam logic [3:0] src_software = 4'h8;
  localparam logic [3:0] src_external = 4'h9;
  localparam logic [15:0] reg_zero = 16'h0000;
  // conversion time of the on-board converter, in ns
  localparam int adc_conv_ns = 10000;
  localparam int clk_period_ns = 25;
  localparam int adc_conv_cycles = (adc_conv_ns + clk_period_ns - 1) /
    clk_period_ns;
endpackage

// [rtl/cal_adc_ctrl.sv]
// conversion sequencer for the on-board calibration converter
// assumes the converter answers with parallel data after a fixed time
`timescale 1ns/10ps
module cal_adc_ctrl #(
  parameter int conv_cycles = cal_trig_pkg::adc_conv_cycles
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] adc_data,
  output logic adc_convert,
  output logic busy,
  output logic [7:0] result
);
  typedef enum {st_idle, st_conv} adc_state_e;
  adc_state_e state, next_state;
  logic [15:0] count, next_count;
  logic [7:0] next_result;

  // the down counter must hold the loaded count
  if (conv_cycles < 1 || conv_cycles > 65535) begin : g_bad_conv
    $error("bad conv_cycles");
  end

  // idle until start, then count out the conversion and capture data
  always_comb begin
    next_state = state;
    next_count = count;
    next_result = result;
    case (state)
      st_idle: begin
        if (start) begin
          next_state = st_conv;
          next_count = 16'(conv_cycles - 1);
        end
      end
      st_conv: begin
        if (count == 16'h0000) begin
          next_state = st_idle;
          next_result = adc_data;
        end else begin
          next_count = count - 16'h0001;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      count <= 16'h0000;
      result <= 8'h00;
    end else begin
      state <= next_state;
      count <= next_count;
      result <= next_result;
    end
  end

  assign busy = (state == st_conv);
  assign adc_convert = busy;

  // busy lasts exactly conv_cycles: loaded, stepped down, then released
  a_busy_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(busy) |-> count == 16'(conv_cycles - 1))
    else $error("conversion count not loaded");
  a_busy_step: assert property (
    @(posedge sys_clk) disable iff (rst)
    busy && count != 16'h0000 |=>
    busy && count == $past(count) - 16'h0001)
    else $error("conversion count not stepping");
  a_busy_len: assert property (
    @(posedge sys_clk) disable iff (rst)
    busy && count == 16'h0000 |=> !busy)
    else $error("busy length wrong");
endmodule // cal_adc_ctrl

// [rtl/cal_trig_regs.sv]
// calibration, configuration and trigger registers of the converter card
// assumes a one-cycle register strobe port already decoded for this card
`timescale 1ns/10ps
module cal_trig_regs #(
  parameter int conv_cycles = cal_trig_pkg::adc_conv_cycles
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic eight_chan,
  input wire logic [2:0] terminal_ident_line,
  input wire logic [7:0] adc_data,
  output logic adc_convert,
  output logic cal_bus_connect,
  output logic cal_volt_sel,
  output logic cal_mux_oe,
  output logic [3:0] cal_mux_chan,
  output logic adc_scale_div,
  input wire logic [7:0] ttl_trig_in,
  input wire logic ext_trig_in,
  output logic [7:0] ttl_trig_out,
  output logic [7:0] ttl_trig_oe,
  output logic trig_event
);
  logic bus_en, next_bus_en;
  logic mode_volt, next_mode_volt;
  logic mux_en, next_mux_en;
  logic [3:0] chan, next_chan;
  logic scale, next_scale;
  logic trig_en, next_trig_en;
  logic [2:0] drv, next_drv;
  logic [1:0] mode, next_mode;
  logic [3:0] src, next_src;
  logic [7:0] ttl_prev, next_ttl_prev;
  logic ext_prev, next_ext_prev;
  logic trig_event_q, next_trig_event;
  logic [15:0] rdata_q, next_rdata;
  logic adc_start, adc_busy;
  logic [7:0] adc_result;
  logic cal_wr, trig_wr, sw_wr;
  logic src_edge;

  ////////////////////////////////////////////////////////////////////////
  // conversion engine

  cal_adc_ctrl #(.conv_cycles(conv_cycles)) u_adc (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(adc_start),
    .adc_data(adc_data),
    .adc_convert(adc_convert),
    .busy(adc_busy),
    .result(adc_result)
  );

  ////////////////////////////////////////////////////////////////////////
  // write decode

  // register match, shared by every write strobe
  function automatic logic addr_hit(
    input logic [4:0] addr,
    input logic [4:0] off
  );
    return addr == off;
  endfunction

  assign cal_wr = reg_wr && addr_hit(reg_addr, cal_trig_pkg::off_cal_ctrl);
  assign trig_wr = reg_wr && addr_hit(reg_addr, cal_trig_pkg::off_trig_ctrl);
  assign sw_wr = reg_wr && addr_hit(reg_addr, cal_trig_pkg::off_sw_trig);
  assign adc_start = cal_wr && reg_wdata[cal_trig_pkg::bit_adc_busy];

  // calibration and trigger control fields
  always_comb begin
    next_bus_en = bus_en;
    next_mode_volt = mode_volt;
    next_mux_en = mux_en;
    next_chan = chan;
    next_scale = scale;
    next_trig_en = trig_en;
    next_drv = drv;
    next_mode = mode;
    next_src = src;
    if (cal_wr) begin
      next_bus_en = reg_wdata[cal_trig_pkg::bit_bus_en];
      next_mode_volt = reg_wdata[cal_trig_pkg::bit_mode_volt];
      next_mux_en = reg_wdata[cal_trig_pkg::bit_mux_en];
      next_chan = reg_wdata[cal_trig_pkg::chan_hi:cal_trig_pkg::chan_lo];
      next_scale = reg_wdata[cal_trig_pkg::bit_adc_scale];
    end
    if (trig_wr) begin
      next_trig_en = reg_wdata[cal_trig_pkg::bit_trig_en];
      next_drv = reg_wdata[cal_trig_pkg::drv_hi:cal_trig_pkg::drv_lo];
      next_mode = reg_wdata[cal_trig_pkg::mode_hi:cal_trig_pkg::mode_lo];
      next_src = reg_wdata[cal_trig_pkg::src_hi:cal_trig_pkg::src_lo];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_en <= 1'b0;
      mode_volt <= 1'b0;
      mux_en <= 1'b0;
      chan <= 4'h0;
      scale <= 1'b0;
      trig_en <= 1'b0;
      drv <= 3'h0;
      mode <= cal_trig_pkg::mode_receive;
      src <= 4'h0;
    end else begin
      bus_en <= next_bus_en;
      mode_volt <= next_mode_volt;
      mux_en <= next_mux_en;
      chan <= next_chan;
      scale <= next_scale;
      trig_en <= next_trig_en;
      drv <= next_drv;
      mode <= next_mode;
      src <= next_src;
    end
  end

  // calibration path drive
  assign cal_bus_connect = bus_en;
  assign cal_volt_sel = mode_volt;
  assign cal_mux_oe = mux_en;
  assign cal_mux_chan = mux_en ? chan : 4'h0;
  assign adc_scale_div = scale;

  ////////////////////////////////////////////////////////////////////////
  // trigger system: backplane lines are active low

  // falling edge on the selected source, or a software strobe
  always_comb begin
    src_edge = 1'b0;
    if (src == cal_trig_pkg::src_software)
      src_edge = sw_wr;
    else if (src == cal_trig_pkg::src_external)
      src_edge = ext_prev && !ext_trig_in;
    else if (!src[3])
      src_edge = ttl_prev[src[2:0]] && !ttl_trig_in[src[2:0]];
  end

  always_comb begin
    next_ttl_prev = ttl_trig_in;
    next_ext_prev = ext_trig_in;
    next_trig_event = trig_en && src_edge;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ttl_prev <= 8'hff;
      ext_prev <= 1'b1;
      trig_event_q <= 1'b0;
    end else begin
      ttl_prev <= next_ttl_prev;
      ext_prev <= next_ext_prev;
      trig_event_q <= next_trig_event;
    end
  end

  assign trig_event = trig_event_q;
  // relay-out pulls the chosen line low for one cycle per trigger
  always_comb begin
    ttl_trig_oe = 8'h00;
    if (trig_event_q && mode == cal_trig_pkg::mode_relay)
      ttl_trig_oe[drv] = 1'b1;
  end
  assign ttl_trig_out = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered

  always_comb begin
    next_rdata = cal_trig_pkg::reg_zero;
    if (reg_rd) begin
      case (reg_addr)
        cal_trig_pkg::off_cal_ctrl: begin
          next_rdata[cal_trig_pkg::bit_bus_en] = bus_en;
          next_rdata[cal_trig_pkg::bit_adc_busy] = adc_busy;
          next_rdata[cal_trig_pkg::bit_mode_volt] = mode_volt;
          next_rdata[cal_trig_pkg::bit_mux_en] = mux_en;
          next_rdata[cal_trig_pkg::chan_hi:cal_trig_pkg::chan_lo] = chan;
          next_rdata[cal_trig_pkg::res_hi:cal_trig_pkg::res_lo] =
            adc_result;
        end
        cal_trig_pkg::off_card_cfg: begin
          next_rdata[cal_trig_pkg::cfg_hi:cal_trig_pkg::cfg_lo] =
            {3{eight_chan}};
          next_rdata[cal_trig_pkg::term_hi:cal_trig_pkg::term_lo] =
            terminal_ident_line;
        end
        cal_trig_pkg::off_trig_ctrl: begin
          next_rdata[cal_trig_pkg::bit_trig_en] = trig_en;
          next_rdata[cal_trig_pkg::drv_hi:cal_trig_pkg::drv_lo] = drv;
          next_rdata[cal_trig_pkg::mode_hi:cal_trig_pkg::mode_lo] = mode;
          next_rdata[cal_trig_pkg::src_hi:cal_trig_pkg::src_lo] = src;
        end
        default: next_rdata = cal_trig_pkg::reg_zero;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      rdata_q <= cal_trig_pkg::reg_zero;
    else
      rdata_q <= next_rdata;
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence sw_strobe_s;
    sw_wr && trig_en && src == cal_trig_pkg::src_software;
  endsequence
  sequence ext_fall_s;
    trig_en && src == cal_trig_pkg::src_external && ext_prev && !ext_trig_in;
  endsequence
  sequence line_fall_s;
    trig_en && !src[3] && ttl_prev[src[2:0]] && !ttl_trig_in[src[2:0]];
  endsequence
  sequence cal_read_s;
    reg_rd && reg_addr == cal_trig_pkg::off_cal_ctrl;
  endsequence
  sequence trig_read_s;
    reg_rd && reg_addr == cal_trig_pkg::off_trig_ctrl;
  endsequence

  a_sw_trig_fire: assert property (
    @(posedge sys_clk) disable iff (rst)
    sw_strobe_s |=> trig_event)
    else $error("software write gave no trigger");
  a_ext_fire: assert property (
    @(posedge sys_clk) disable iff (rst)
    ext_fall_s |=> trig_event)
    else $error("external edge gave no trigger");
  a_line_fire: assert property (
    @(posedge sys_clk) disable iff (rst)
    line_fall_s |=> trig_event)
    else $error("backplane edge gave no trigger");
  a_trig_off_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(trig_en) |-> !trig_event)
    else $error("trigger while disabled");
  a_relay_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    trig_event && mode == cal_trig_pkg::mode_relay |->
    ttl_trig_oe == (8'h01 << drv))
    else $error("wrong drive line");
  a_one_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    ttl_trig_oe != 8'h00 |-> $onehot(ttl_trig_oe) && trig_event)
    else $error("stray drive on the backplane");
  a_receive_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == cal_trig_pkg::mode_receive |-> ttl_trig_oe == 8'h00)
    else $error("drive in receive mode");
  a_mux_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    !mux_en |-> cal_mux_chan == 4'h0)
    else $error("channel active while selector off");
  a_chan_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    cal_wr && reg_wdata[cal_trig_pkg::bit_mux_en] |=>
    cal_mux_chan ==
    $past(reg_wdata[cal_trig_pkg::chan_hi:cal_trig_pkg::chan_lo]))
    else $error("channel code not applied");
  a_bus_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    cal_wr |=>
    cal_bus_connect == $past(reg_wdata[cal_trig_pkg::bit_bus_en]))
    else $error("bus connect not stored");
  a_volt_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    cal_wr |=>
    cal_volt_sel == $past(reg_wdata[cal_trig_pkg::bit_mode_volt]))
    else $error("quantity select not stored");
  a_scale_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    cal_wr |=>
    adc_scale_div == $past(reg_wdata[cal_trig_pkg::bit_adc_scale]))
    else $error("scale select not stored");
  a_cal_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !cal_wr |=> $stable({cal_bus_connect, cal_volt_sel, cal_mux_oe,
    cal_mux_chan, adc_scale_div}))
    else $error("calibration outputs moved without a write");
  a_trig_write: assert property (
    @(posedge sys_clk) disable iff (rst)
    trig_wr |=> trig_en == $past(reg_wdata[cal_trig_pkg::bit_trig_en]))
    else $error("trigger enable not stored");
  a_start_busy: assert property (
    @(posedge sys_clk) disable iff (rst)
    adc_start && !adc_busy |=> adc_busy)
    else $error("conversion not started");
  a_cal_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    cal_read_s |=> reg_rdata == {$past(bus_en), $past(adc_busy),
    $past(mode_volt), $past(mux_en), $past(chan), $past(adc_result)})
    else $error("calibration read wrong");
  a_trig_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    trig_read_s |=> reg_rdata == {$past(trig_en), 6'h00, $past(drv),
    $past(mode), $past(src)})
    else $error("trigger control read wrong");
  a_cfg_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == cal_trig_pkg::off_card_cfg |=>
    reg_rdata == {10'h000, {3{$past(eight_chan)}},
    $past(terminal_ident_line)})
    else $error("card config read wrong");
  a_unmapped_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == cal_trig_pkg::off_sw_trig |=>
    reg_rdata == 16'h0000)
    else $error("write-only register read nonzero");
  a_idle_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data without a read");
endmodule // cal_trig_regs

// [sim/card_far_side.sv]
// converter and backplane lines seen from the register bank
// assumes lines are open-drain with pull-ups, pulled by the bench
`timescale 1ns/10ps
module card_far_side (
  input wire logic adc_convert,
  input wire logic [7:0] adc_code,
  input wire logic [7:0] ttl_trig_oe,
  input wire logic [7:0] line_pull,
  output logic [7:0] adc_data,
  output logic [7:0] ttl_trig_in
);
  // converter data is only good while converting, else inverted
  assign adc_data = adc_convert ? adc_code : ~adc_code;
  // wired-and backplane lines; drive and source differ
  assign ttl_trig_in = ~(ttl_trig_oe | line_pull);
endmodule // card_far_side

// [sim/testbench.sv]
// self-checking bench for the calibration and trigger registers
// assumes cal_trig_regs built with conv_cycles shortened to 4
`timescale 1ns/10ps
module testbench;
  localparam int conv = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic eight_chan = 1'b0;
  logic [2:0] term = 3'h0;
  logic [7:0] adc_code = 8'h5a;
  logic [7:0] adc_data;
  logic adc_convert;
  wire [7:0] outs;
  wire [7:0] trig_out;
  logic [7:0] ttl_trig_in;
  logic [7:0] line_pull = 8'h00;
  logic ext_trig_n = 1'b1;
  logic [7:0] ttl_trig_oe;
  logic trig_event;
  logic [15:0] n_ev = 16'h0000;
  logic [7:0] seen_oe = 8'h00;
  int cycles = 0;
  int n_tests = 0;
  int failures = 0;

  always #12.5 sys_clk = ~sys_clk;

  cal_trig_regs #(.conv_cycles(conv)) dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .eight_chan(eight_chan),
    .terminal_ident_line(term), .adc_data(adc_data),
    .adc_convert(adc_convert), .cal_bus_connect(outs[7]),
    .cal_volt_sel(outs[6]), .cal_mux_oe(outs[5]),
    .cal_mux_chan(outs[3:0]), .adc_scale_div(outs[4]),
    .ttl_trig_in(ttl_trig_in), .ext_trig_in(ext_trig_n),
    .ttl_trig_out(trig_out), .ttl_trig_oe(ttl_trig_oe),
    .trig_event(trig_event)
  );

  card_far_side far (
    .adc_convert(adc_convert), .adc_code(adc_code),
    .ttl_trig_oe(ttl_trig_oe), .line_pull(line_pull),
    .adc_data(adc_data), .ttl_trig_in(ttl_trig_in)
  );

  ////////////////////////////////////////////////////////////////////
  // event monitor and hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    seen_oe <= seen_oe | ttl_trig_oe;
    if (trig_event === 1'b1) begin
      n_ev <= n_ev + 16'h0001;
    end
    if (cycles == 4000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write strobe, driven at the falling edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // read data is registered and stands the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), e, reg_rdata);
  endtask

  // event count so far and lines driven since the last check
  task automatic tchk(input logic [15:0] n, input logic [7:0] oe);
    repeat (3) @(negedge sys_clk);
    chk("events", n, n_ev);
    chk("drive", {8'h00, oe}, {8'h00, seen_oe});
    chk("line level", 16'h0000, {8'h00, trig_out});
    seen_oe = 8'h00;
  endtask

  // prev is the result of the conversion before, still shown while busy
  task automatic conv_run(input logic [7:0] code, input logic [7:0] prev);
    adc_code = code;
    wr(5'h08, 16'h4000);
    @(negedge sys_clk);
    chk("convert", 16'h0001, {15'h0, adc_convert});
    rd(5'h08, {8'h40, prev});
    repeat (conv + 2) @(negedge sys_clk);
    rd(5'h08, {8'h00, code});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    rd(5'h08, 16'h0000);
    rd(5'h0e, 16'h0000);
    rd(5'h0c, 16'h0000);
    rd(5'h10, 16'h0000);
    $display("test reset done");
    // control fields; low byte reads the result, not the write
    wr(5'h08, 16'hbfa5);
    rd(5'h08, 16'hbf00);
    chk("pins", 16'h00ff, {8'h00, outs});
    wr(5'h08, 16'h2500);
    rd(5'h08, 16'h2500);
    chk("pins", 16'h0040, {8'h00, outs});
    // relay settling is the host's wait; pin checks do not rely on it
    wr(5'h08, 16'h9300);
    chk("pins", 16'h00a3, {8'h00, outs});
    $display("test cal fields done");
    conv_run(8'h5a, 8'h00);
    conv_run(8'ha5, 8'h5a);
    $display("test conversion done");
    wr(5'h0a, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      eight_chan = i[0];
      term = {i[1], i[0], i[1]};
      rd(5'h0a, {10'h0, {3{i[0]}}, i[1], i[0], i[1]});
    end
    $display("test config done");
    // software source, relay out on line 3
    wr(5'h0e, 16'h80f8);
    rd(5'h0e, 16'h80f8);
    wr(5'h0c, 16'h1234);
    tchk(16'h0001, 8'h08);
    wr(5'h0c, 16'h0000);
    wr(5'h0c, 16'hffff);
    tchk(16'h0003, 8'h08);
    wr(5'h0e, 16'h00f8);
    wr(5'h0c, 16'h0000);
    tchk(16'h0003, 8'h00);
    // every backplane source, driving the next line up, line 0 after line 7
    for (int i = 0; i < 8; i++) begin
      wr(5'h0e, 16'h8030 | 16'(((i + 1) % 8) << 6) | 16'(i));
      line_pull[i] = 1'b1;
      @(negedge sys_clk);
      line_pull[i] = 1'b0;
      tchk(16'(i + 4), 8'(1 << ((i + 1) % 8)));
    end
    wr(5'h0e, 16'hfff2);
    rd(5'h0e, 16'h81f2);
    wr(5'h0c, 16'h0000);
    tchk(16'h000b, 8'h00);
    // mode code 01 acts as receive-only and drives nothing
    wr(5'h0e, 16'h80d8);
    wr(5'h0c, 16'h0000);
    tchk(16'h000c, 8'h00);
    // external source in receive mode drives nothing
    wr(5'h0e, 16'h81c9);
    ext_trig_n = 1'b0;
    @(negedge sys_clk);
    ext_trig_n = 1'b1;
    tchk(16'h000d, 8'h00);
    $display("test trigger done");
    stop_test();
  end
endmodule // testbench
